/* design/sector_cfg_pkg.sv */
// Functional notes
// - Suspend status reads invalid during any reset, power-down exit or chip-select reset.
// - Bit 6 zero groups small sectors together; one splits them evenly; default zero.
// - Bit 2 zero places grouped small sectors at bottom, one at top.
// - Split selection overrides the top/bottom selection.
// - Small sector block replaces part of the end large sector, no added space.
// - Bit 5 zero keeps top half readable under read password; one the bottom half.
// - Permanent lock is one-time settable in nonvolatile copy, read-only in volatile.
// - Permanent lock set makes layout and readable-half bits read-only forever.
// - Temporary lock writable only in volatile copy; blocks layout changes until any reset, power-down exit or chip-select reset.
// - Either lock protects split, top/bottom and readable-half bits from program and erase.
package sector_cfg_pkg;
	localparam logic [3:0] nonvolatile_offset = 4'h0;
	localparam logic [3:0] volatile_offset = 4'h4;
	localparam logic [3:0] status_offset = 4'h8;
	localparam logic [3:0] control_offset = 4'hc;
	localparam int split_bit = 6;
	localparam int readable_bit = 5;
	localparam int perm_lock_bit = 4;
	localparam int top_bottom_bit = 2;
	localparam int temp_lock_bit = 0;
	localparam logic [7:0] config_reset = 8'h00;
	localparam logic [7:0] layout_mask = 8'h64;
	localparam logic [7:0] reserved_mask = 8'h8a;
	localparam int status_busy_bit = 0;
	localparam int status_valid_bit = 1;

	typedef struct packed {
		logic split_small_sectors;
		logic small_sector_top_bottom;
		logic readable_half_select;
		logic permanent_layout_lock;
		logic temporary_layout_lock;
	} layout_type;
endpackage : sector_cfg_pkg

/* design/sector_layout_config_register.sv */
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sector_layout_config_register (
	input wire logic clk, // 25 MHz system clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic clk_en, // Freezes all state while low, except that rst_n still resets
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [3:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lane selects
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic busy_in, // Array operation in progress
	input wire logic array_erase_in, // Array erase request for protection check
	input wire logic dpd_exit_in, // Deep power-down exit pulse
	input wire logic cs_reset_in, // Chip-select signalling reset pulse
	output sector_cfg_pkg::layout_type layout_o, // Active layout selection
	output logic suspend_status_valid_o, // Suspend status may be trusted
	output logic erase_blocked_o // Array erase refused by lock
);
	// Cells leave the factory at their default; resets never touch them
	logic [7:0] nonvolatile_ff = sector_cfg_pkg::config_reset;
	logic [7:0] volatile_ff;
	logic suspend_valid_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic split_ff;
	logic top_bottom_ff;
	logic readable_ff;
	logic perm_lock_ff;
	logic temp_lock_ff;
	logic erase_blocked_ff;
	logic busy_meta_ff, busy_sync_ff;
	logic dpd_meta_ff, dpd_sync_ff;
	logic csr_meta_ff, csr_sync_ff;
	logic erase_meta_ff, erase_sync_ff;
	logic req;
	logic rd_req;
	logic wr_lane0;
	logic wr_nonvolatile;
	logic wr_volatile;
	logic perm_locked;
	logic temp_locked;
	logic locked;
	logic reload_ff;
	logic [7:0] nxt_nonvolatile;
	logic [7:0] nxt_volatile;
	logic [31:0] nxt_rdata;

	// A request is taken once, while ack is still low
	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign rd_req = req && !wb_we_i;
	// Writes land at the edge where the master sees ack high
	assign wr_lane0 = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
	assign wr_nonvolatile = wr_lane0 && (wb_adr_i == sector_cfg_pkg::nonvolatile_offset);
	assign wr_volatile = wr_lane0 && (wb_adr_i == sector_cfg_pkg::volatile_offset);
	assign perm_locked = nonvolatile_ff[sector_cfg_pkg::perm_lock_bit];
	assign temp_locked = volatile_ff[sector_cfg_pkg::temp_lock_bit];
	// Either lock freezes the layout fields
	assign locked = perm_locked || temp_locked;

	// Busy flag comes from the array, another timing domain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_meta_ff <= 1'b0;
			busy_sync_ff <= 1'b0;
		end else if (clk_en) begin
			busy_meta_ff <= busy_in;
			busy_sync_ff <= busy_meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dpd_meta_ff <= 1'b0;
			dpd_sync_ff <= 1'b0;
		end else if (clk_en) begin
			dpd_meta_ff <= dpd_exit_in;
			dpd_sync_ff <= dpd_meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			csr_meta_ff <= 1'b0;
			csr_sync_ff <= 1'b0;
		end else if (clk_en) begin
			csr_meta_ff <= cs_reset_in;
			csr_sync_ff <= csr_meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			erase_meta_ff <= 1'b0;
			erase_sync_ff <= 1'b0;
		end else if (clk_en) begin
			erase_meta_ff <= array_erase_in;
			erase_sync_ff <= erase_meta_ff;
		end
	end

	always_comb begin
		nxt_nonvolatile = nonvolatile_ff;
		if (wr_nonvolatile) begin
			if (!locked) begin
				nxt_nonvolatile = (nonvolatile_ff & ~sector_cfg_pkg::layout_mask) |
					(wb_dat_i[7:0] & sector_cfg_pkg::layout_mask);
			end
			// Lock bit only ever moves zero to one
			if (wb_dat_i[sector_cfg_pkg::perm_lock_bit]) begin
				nxt_nonvolatile[sector_cfg_pkg::perm_lock_bit] = 1'b1;
			end
			// Reserved bits hold what the host wrote
			nxt_nonvolatile[7] = wb_dat_i[7];
			nxt_nonvolatile[3] = wb_dat_i[3];
			nxt_nonvolatile[1] = wb_dat_i[1];
		end
	end

	// Nonvolatile copy survives resets, modelling flash cells
	always_ff @(posedge clk) begin
		if (clk_en) begin
			nonvolatile_ff <= nxt_nonvolatile;
		end
	end

	always_comb begin
		nxt_volatile = volatile_ff;
		// Every reset kind reloads, the pin reset one cycle after release
		if (reload_ff || dpd_sync_ff || csr_sync_ff) begin
			nxt_volatile = nonvolatile_ff;
			nxt_volatile[sector_cfg_pkg::temp_lock_bit] = 1'b0;
		end else if (wr_volatile) begin
			// Temporary lock sets only; clears on every reset kind
			if (wb_dat_i[sector_cfg_pkg::temp_lock_bit]) begin
				nxt_volatile[sector_cfg_pkg::temp_lock_bit] = 1'b1;
			end
			nxt_volatile[7] = wb_dat_i[7];
			nxt_volatile[3] = wb_dat_i[3];
			nxt_volatile[1] = wb_dat_i[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			volatile_ff <= sector_cfg_pkg::config_reset;
		end else if (clk_en) begin
			volatile_ff <= nxt_volatile;
		end
	end

	// Reset reload runs one cycle after release: nonvolatile isn't reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reload_ff <= 1'b1;
		end else if (clk_en) begin
			reload_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			split_ff <= 1'b0;
		end else if (clk_en) begin
			split_ff <= volatile_ff[sector_cfg_pkg::split_bit];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			top_bottom_ff <= 1'b0;
		end else if (clk_en) begin
			top_bottom_ff <= volatile_ff[sector_cfg_pkg::top_bottom_bit];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readable_ff <= 1'b0;
		end else if (clk_en) begin
			readable_ff <= volatile_ff[sector_cfg_pkg::readable_bit];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			perm_lock_ff <= 1'b0;
		end else if (clk_en) begin
			perm_lock_ff <= volatile_ff[sector_cfg_pkg::perm_lock_bit];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			temp_lock_ff <= 1'b0;
		end else if (clk_en) begin
			temp_lock_ff <= volatile_ff[sector_cfg_pkg::temp_lock_bit];
		end
	end

	// Array erase request is refused while locked
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			erase_blocked_ff <= 1'b0;
		end else if (clk_en) begin
			erase_blocked_ff <= erase_sync_ff && locked;
		end
	end

	// Any reset event makes suspend status invalid until idle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			suspend_valid_ff <= 1'b0;
		end else if (clk_en) begin
			if (dpd_sync_ff || csr_sync_ff || reload_ff) begin
				suspend_valid_ff <= 1'b0;
			end else begin
				suspend_valid_ff <= !busy_sync_ff;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else if (clk_en) begin
			ack_ff <= req;
		end
	end

	// Read data is zero whenever no read is answered
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (rd_req) begin
			unique case (wb_adr_i)
				sector_cfg_pkg::nonvolatile_offset: nxt_rdata = {24'h000000, nonvolatile_ff};
				sector_cfg_pkg::volatile_offset: nxt_rdata = {24'h000000, volatile_ff};
				sector_cfg_pkg::status_offset: nxt_rdata = {30'h0, suspend_valid_ff,
					busy_sync_ff};
				default: nxt_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_ff <= 32'h00000000;
		end else if (clk_en) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign layout_o.split_small_sectors = split_ff;
	assign layout_o.small_sector_top_bottom = top_bottom_ff;
	assign layout_o.readable_half_select = readable_ff;
	assign layout_o.permanent_layout_lock = perm_lock_ff;
	assign layout_o.temporary_layout_lock = temp_lock_ff;
	assign suspend_status_valid_o = suspend_valid_ff;
	assign erase_blocked_o = erase_blocked_ff;
endmodule : sector_layout_config_register
`default_nettype wire

/* dv/array_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module array_side_model (
	input wire logic clk, // Clock
	input wire logic [1:0] event_req, // Pulse: bit0 chip-select reset, bit1 power-down exit
	output logic [1:0] event_o // Reset events toward the block
);
	logic [1:0] kind_ff = 2'h0;
	logic [2:0] hold_ff = 3'h0;
	// Held four cycles so the block's synchronizer cannot miss a short event
	always_ff @(posedge clk) begin
		kind_ff <= (event_req != 2'h0) ? event_req : kind_ff;
		hold_ff <= (event_req != 2'h0) ? 3'h4 : hold_ff - {2'h0, hold_ff != 3'h0};
	end
	assign event_o = (hold_ff != 3'h0) ? kind_ff : 2'h0;
endmodule : array_side_model
`default_nettype wire

/* dv/sector_cfg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sector_cfg_monitor (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic wb_stb_i, // Strobe
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire logic busy_in, // Busy flag
	input wire logic cs_reset_in, // Reload event
	input wire sector_cfg_pkg::layout_type layout_o, // Layout
	input wire logic suspend_status_valid_o, // Suspend status valid
	input wire logic erase_blocked_o // Erase refused
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_latency: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack unasked");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
	a_perm_sticky: assert property (layout_o.permanent_layout_lock |=>
		layout_o.permanent_layout_lock) else $error("lock lost");
	a_reload_invalid: assert property ($rose(cs_reset_in) |->
		##[1:4] !suspend_status_valid_o) else $error("valid in reset");
	a_busy_invalid: assert property (busy_in [*4] |=>
		!suspend_status_valid_o) else $error("valid when busy");
	a_block_lock: assert property (erase_blocked_o |-> layout_o.permanent_layout_lock ||
		layout_o.temporary_layout_lock || $past(layout_o.temporary_layout_lock))
		else $error("blocked unlocked");
endmodule : sector_cfg_monitor
bind sector_layout_config_register sector_cfg_monitor sector_cfg_monitor_i (.clk(clk),
	.rst_n(rst_n), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.busy_in(busy_in), .cs_reset_in(cs_reset_in), .layout_o(layout_o),
	.suspend_status_valid_o(suspend_status_valid_o), .erase_blocked_o(erase_blocked_o));
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, busy = 1'b0, erase = 1'b0;
	logic ack, valid, blocked;
	logic [1:0] ev = 2'h0, evt;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, got;
	sector_cfg_pkg::layout_type lay;
	int miscompares = 0, compares = 0;
	// Rows: write, address, write data, expected read data
	logic [20:0] rows [7] = '{21'h100000, 21'h000000, 21'h106400, 21'h000064, 21'h146400,
		21'h040000, 21'h0c0000};
	sector_layout_config_register sector_layout_config_register_i (.clk(clk), .rst_n(rst_n),
		.clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_in(busy),
		.array_erase_in(erase), .dpd_exit_in(evt[1]), .cs_reset_in(evt[0]), .layout_o(lay),
		.suspend_status_valid_o(valid), .erase_blocked_o(blocked));
	array_side_model array_side_model_i (.clk(clk), .event_req(ev), .event_o(evt));
	initial forever #20 clk = ~clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		miscompares += int'(g !== e);
		if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
	endtask : chk
	task automatic bus(input logic [20:0] r);
		int n = 0;
		@(posedge clk);
		{cyc, we, adr, wdat} <= {1'b1, r[20:16], 24'h0, r[15:8]};
		do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
		if (ack !== 1'b1) miscompares++;
		got = rdat;
		cyc <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		#200us;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i]);
			if (!rows[i][20]) chk(got, {24'h0, rows[i][7:0]});
		end
		$display("register table done");
		ev <= 2'h1;
		@(posedge clk);
		ev <= 2'h0;
		repeat (8) @(posedge clk);
		chk({27'h0, lay}, 32'h1c);
		bus(21'h140100);
		bus(21'h100000);
		bus(21'h000000);
		chk(got, 32'h64);
		erase <= 1'b1;
		repeat (6) @(posedge clk);
		chk({31'h0, blocked}, 32'h1);
		{erase, busy} <= 2'h1;
		repeat (6) @(posedge clk);
		chk({31'h0, valid}, 32'h0);
		{busy, ev} <= 3'h2;
		@(posedge clk);
		ev <= 2'h0;
		repeat (8) @(posedge clk);
		chk({27'h0, lay}, 32'h1c);
		$display("temporary lock done");
		bus(21'h107400);
		bus(21'h100000);
		// Mid-run reset must not touch the nonvolatile copy
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		bus(21'h000000);
		chk(got, 32'h74);
		chk({27'h0, lay}, 32'h1e);
		$display("permanent lock done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
